// [rtl/stpt_pkg.sv]
// Purpose: Types of the pole trip block
// Assumes: Constants live in stpt_regs.svh
// Notes:   Configuration travels as one packed struct
`include "stpt_regs.svh"

package stpt_pkg;

   typedef struct packed {
      logic                      force_3ph;   // Force three-phase trip
      logic                      gdiff_1p;    // Single-phase trip, ground differential
      logic                      goc_1p;      // Single-phase trip, ground overcurrent
      logic                      fd_sup;      // Supervision by fault detector
      logic                      reduced;     // Single breaker trip variant
      logic [`STPT_DIFF_W-1:0]   diff_mask;
      logic [`STPT_AUX_W-1:0]    aux_mask;
   } stpt_cfg_s;

   typedef enum logic [1:0] {
      STPT_POLE_IDLE = 2'h1,
      STPT_POLE_TRIP = 2'h2
   } stpt_pole_e;

endpackage : stpt_pkg

// [rtl/stpt_pole.sv]
// Purpose: One single-phase pole trip sub-logic with its latch
// Assumes: All inputs are on clock_i
// Notes:   Clear beats set so a block is never overridden
`timescale 1ns/1ps
`default_nettype none

module stpt_pole (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic cmd_i,
   input  wire logic ready_i,
   input  wire logic sel_i,
   input  wire logic block_i,
   input  wire logic release_i,
   output logic      trip_o
);

   stpt_pkg::stpt_pole_e state_q;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= stpt_pkg::STPT_POLE_IDLE;
      end
      else
      begin
         case (state_q)
            stpt_pkg::STPT_POLE_IDLE:
            begin
               if (cmd_i && (sel_i || ready_i) && !block_i && !release_i)
               begin
                  state_q <= stpt_pkg::STPT_POLE_TRIP;
               end
            end
            stpt_pkg::STPT_POLE_TRIP:
            begin
               // Holds after the elements drop out
               if (block_i || release_i)
               begin
                  state_q <= stpt_pkg::STPT_POLE_IDLE;
               end
            end
            default:
            begin
               state_q <= stpt_pkg::STPT_POLE_IDLE;
            end
         endcase
      end
   end

   assign trip_o = (state_q == stpt_pkg::STPT_POLE_TRIP);

endmodule : stpt_pole

`default_nettype wire

// [rtl/stpt_regs.svh]
// Purpose: Named constants of the single/three-phase pole trip block
// Assumes: Aux mask bit order as listed below, one bit per element
// Notes:   Aux element bit order and stage 1 select mask follow
`ifndef STPT_REGS_SVH
`define STPT_REGS_SVH

`define STPT_NPOLE       3
`define STPT_DIFF_W      3
`define STPT_DIFF_PH     0
`define STPT_DIFF_GND    1
`define STPT_DIFF_NEG    2
// Aux order: thermal, open phase, pole discord, ph toc1-3, ph ioc1-3,
// gnd toc1-3, gnd ioc1-3, neg toc1-3, neg ioc1-3, uv1-3, ov1-3,
// gnd ov1-2, uf1-3, of1-3, roc1-3
`define STPT_AUX_W       38
// Stage 1 of ground and negative sequence overcurrent (toc and ioc)
`define STPT_AUX_G1_SEL  38'h00_0004_9200
`define STPT_AUX_NONE    38'h00_0000_0000
`define STPT_DIFF_NONE   3'h0
`define STPT_POLE_NONE   3'h0
`define STPT_POLE_ALL    3'h7

`endif

// [rtl/stpt_trip.sv]
// Purpose: Pole level trip logic: masks, command, per-pole latches
// Assumes: Element pickups and block inputs are already on clock_i
// Notes:   Latched outputs lag their cause by one clock edge; trip_cmd_o and all_pole_ready_o are combinational
`timescale 1ns/1ps
`default_nettype none
`include "stpt_regs.svh"

module stpt_trip (
   input  wire logic                      clock_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      cfg_we_i,
   input  wire stpt_pkg::stpt_cfg_s       cfg_i,
   output stpt_pkg::stpt_cfg_s            cfg_o,
   output logic                           gdiff_1p_eff_o,
   input  wire logic [`STPT_DIFF_W-1:0]   diff_trip_i,
   input  wire logic [`STPT_NPOLE-1:0]    diff_ph_pole_i,
   input  wire logic [`STPT_AUX_W-1:0]    aux_trip_i,
   input  wire logic                      scheme_trip_i,
   input  wire logic                      prog_trip_i,
   input  wire logic                      fault_det_i,
   input  wire logic [`STPT_NPOLE-1:0]    fault_pole_i,
   input  wire logic                      all_pole_ready_i,
   input  wire logic                      pole_a_block_in_i,
   input  wire logic                      pole_b_block_in_i,
   input  wire logic                      pole_c_block_in_i,
   input  wire logic                      general_trip_block_in_i,
   output logic                           trip_cmd_o,
   output logic                           all_pole_ready_o,
   output logic [`STPT_NPOLE-1:0]         pole_trip_o,
   output logic                           general_trip_o,
   output logic                           all_pole_trip_o,
   output logic                           breaker_trip_o
);

   stpt_pkg::stpt_cfg_s         cfg_q;
   logic                        all_q;
   logic                        brk_q;
   logic [`STPT_NPOLE-1:0]      pole_q;
   logic [`STPT_NPOLE-1:0]      pole_sel;
   logic [`STPT_NPOLE-1:0]      pole_blk;
   logic                        gdiff_1p_eff;
   logic                        diff_hit;
   logic                        aux_hit;
   logic                        aux_3p;
   logic                        gdiff_3p;
   logic                        ready;
   logic                        cmd;
   logic                        release_all;

   // Any enabled element asserting
   function automatic logic masked_any(input logic [`STPT_AUX_W-1:0] trips,
                                       input logic [`STPT_AUX_W-1:0] mask);
      masked_any = |(trips & mask);
   endfunction : masked_any

   ////////////////////////////////////////////////////////////////////////
   // Settings store
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         cfg_q <= '0;
      end
      else if (cfg_we_i)
      begin
         cfg_q <= cfg_i;
      end
   end

   assign cfg_o          = cfg_q;
   // Stored value kept so software reads back what it wrote
   assign gdiff_1p_eff   = cfg_q.gdiff_1p && !cfg_q.force_3ph;
   assign gdiff_1p_eff_o = gdiff_1p_eff;

   ////////////////////////////////////////////////////////////////////////
   // Trip command and three-phase readiness
   assign diff_hit = masked_any({35'h0_0000_0000, diff_trip_i},
                                {35'h0_0000_0000, cfg_q.diff_mask});
   assign aux_hit  = masked_any(aux_trip_i, cfg_q.aux_mask);
   // Stage 1 ground overcurrent may stay single-phase when allowed
   assign aux_3p   = masked_any(aux_trip_i,
                                cfg_q.aux_mask & ~(cfg_q.goc_1p ? `STPT_AUX_G1_SEL
                                                                : `STPT_AUX_NONE));
   assign gdiff_3p = !gdiff_1p_eff &&
                     (diff_trip_i[`STPT_DIFF_GND] && cfg_q.diff_mask[`STPT_DIFF_GND] ||
                      diff_trip_i[`STPT_DIFF_NEG] && cfg_q.diff_mask[`STPT_DIFF_NEG]);
   assign cmd      = diff_hit || aux_hit || scheme_trip_i || prog_trip_i;
   assign ready    = all_pole_ready_i || cfg_q.force_3ph || aux_3p || gdiff_3p ||
                     prog_trip_i;
   assign trip_cmd_o       = cmd;
   assign all_pole_ready_o = ready;

   // Faulted phase picks the pole; phase differential adds its own pole
   assign pole_sel = fault_pole_i |
                     (cfg_q.diff_mask[`STPT_DIFF_PH] ? diff_ph_pole_i : `STPT_POLE_NONE);
   assign pole_blk = {pole_c_block_in_i, pole_b_block_in_i, pole_a_block_in_i};
   // Detector release only counts while supervision is on
   assign release_all = (cfg_q.fd_sup && !fault_det_i) || general_trip_block_in_i;

   ////////////////////////////////////////////////////////////////////////
   // Per-pole sub-logics, one trip command for all three
   for (genvar p = 0; p < `STPT_NPOLE; p++)
   begin : g_pole
      stpt_pole u_pole (
         .clock_i   (clock_i),
         .rst_n_i   (rst_n_i),
         .cmd_i     (cmd),
         .ready_i   (ready),
         .sel_i     (pole_sel[p]),
         .block_i   (pole_blk[p]),
         .release_i (release_all || cfg_q.reduced),
         .trip_o    (pole_q[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Three-phase trip latch
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         all_q <= 1'b0;
      end
      else if (release_all || cfg_q.reduced)
      begin
         all_q <= 1'b0;
      end
      else if (cmd && ready)
      begin
         all_q <= 1'b1;
      end
   end

   // Direct breaker trip of the reduced variant
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         brk_q <= 1'b0;
      end
      else if (release_all || !cfg_q.reduced)
      begin
         brk_q <= 1'b0;
      end
      else if (cmd)
      begin
         brk_q <= 1'b1;
      end
   end

   assign pole_trip_o     = pole_q;
   assign all_pole_trip_o = all_q;
   assign breaker_trip_o  = brk_q;
   // A pole latch and the breaker latch are never set together
   assign general_trip_o  = brk_q || (|pole_q);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_all_poles_trip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cmd && ready && !release_all && !cfg_q.reduced && pole_blk == `STPT_POLE_NONE
      |=> pole_trip_o == `STPT_POLE_ALL && all_pole_trip_o && general_trip_o)
      else $error("Ready trip did not open all poles");

   a_single_pole: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cmd && !ready && pole_sel == 3'h1 && !release_all && !cfg_q.reduced && !all_q &&
      pole_blk == `STPT_POLE_NONE && pole_q == `STPT_POLE_NONE
      |=> pole_trip_o == 3'h1 && !all_pole_trip_o)
      else $error("Single pole trip wrong");

   a_pole_block: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      pole_a_block_in_i |=> !pole_trip_o[0])
      else $error("Blocked pole tripped");

   a_latch_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      pole_q[1] && !release_all && !pole_b_block_in_i && !cfg_q.reduced
      |=> pole_trip_o[1])
      else $error("Pole trip dropped without release");

   a_detector_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cfg_q.fd_sup && !fault_det_i
      |=> pole_trip_o == `STPT_POLE_NONE && !all_pole_trip_o && !breaker_trip_o)
      else $error("Detector release ignored");

   a_block_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      pole_q[2] ##1 pole_c_block_in_i |=> !pole_trip_o[2])
      else $error("Pole block did not release latch");

   a_reduced_model: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cfg_q.reduced && $past(cfg_q.reduced)
      |-> pole_trip_o == `STPT_POLE_NONE && !all_pole_trip_o)
      else $error("Pole outputs active in reduced variant");

   a_force_gdiff: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      cfg_q.force_3ph |-> !gdiff_1p_eff_o)
      else $error("Ground differential single-phase left enabled");

   a_mask_blocks: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (aux_trip_i & cfg_q.aux_mask) == `STPT_AUX_NONE &&
      (diff_trip_i & cfg_q.diff_mask) == `STPT_DIFF_NONE &&
      !scheme_trip_i && !prog_trip_i |-> !trip_cmd_o)
      else $error("Masked element made a trip command");

   a_general_block: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      general_trip_block_in_i [*2]
      |-> !general_trip_o && !all_pole_trip_o && !breaker_trip_o)
      else $error("Trip output during general block");

   a_reset_defaults: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> cfg_o == '0 && !general_trip_o && !all_pole_trip_o)
      else $error("State not cleared by reset");

endmodule : stpt_trip

`default_nettype wire

// [verif/stpt_elem_model.sv]
// Purpose: Protection element pickups facing the pole trip block
// Assumes: Pickups are levels on clock_i
// Notes:   Thermal image and the stage 1 ground and negative sequence units are the modelled aux units
`timescale 1ns/1ps
`default_nettype none
`include "stpt_regs.svh"

module stpt_elem_model (
   input  wire logic                    therm_i,
   input  wire logic                    g1_i,
   input  wire logic [`STPT_DIFF_W-1:0] diff_i,
   input  wire logic [`STPT_NPOLE-1:0]  fault_i,
   output logic      [`STPT_DIFF_W-1:0] diff_trip_o,
   output logic      [`STPT_NPOLE-1:0]  ph_pole_o,
   output logic      [`STPT_AUX_W-1:0]  aux_trip_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Phase element picks up only on the faulted phases, as a real one would
   assign diff_trip_o = diff_i;
   assign ph_pole_o   = diff_i[`STPT_DIFF_PH] ? fault_i : `STPT_POLE_NONE;
   // Stage 1 ground pickup drives every unit that may stay single-phase
   assign aux_trip_o  = {{(`STPT_AUX_W-1){1'b0}}, therm_i} |
                        (g1_i ? `STPT_AUX_G1_SEL : `STPT_AUX_NONE);
endmodule : stpt_elem_model
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench of the pole trip block
// Assumes: Fixed one-edge latency of every latch
// Notes:   Trip command taken as the masked OR of the present sources
`timescale 1ns/1ps
`default_nettype none
`include "stpt_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module tb;
   logic clock_i = 0, rst_n_i = 0, cfg_we_i = 0, eff, cmd_o, apr, gen, apt, brk;
   logic therm = 0, g1 = 0, ready_in = 0, scheme = 0, prog = 0, fd = 0, gblk = 0;
   logic [2:0] diff_req = 0, fault = 0, blk = 0, pole, diff_trip, ph_pole, mp = 0;
   logic [`STPT_AUX_W-1:0] aux_trip;
   logic [63:0] r;
   logic ma = 0, mb = 0;
   stpt_pkg::stpt_cfg_s cfg = '0, cfg_o, mc = '0;
   int miscompares = 0, n_compared = 0;

   always #2.5 clock_i = ~clock_i;

   stpt_elem_model stpt_elem_model_inst (.therm_i(therm), .g1_i(g1), .diff_i(diff_req),
      .fault_i(fault),
      .diff_trip_o(diff_trip), .ph_pole_o(ph_pole), .aux_trip_o(aux_trip));

   stpt_trip stpt_trip_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we_i),
      .cfg_i(cfg), .cfg_o(cfg_o), .gdiff_1p_eff_o(eff), .diff_trip_i(diff_trip),
      .diff_ph_pole_i(ph_pole), .aux_trip_i(aux_trip), .scheme_trip_i(scheme),
      .prog_trip_i(prog), .fault_det_i(fd), .fault_pole_i(fault),
      .all_pole_ready_i(ready_in), .pole_a_block_in_i(blk[0]), .pole_b_block_in_i(blk[1]),
      .pole_c_block_in_i(blk[2]), .general_trip_block_in_i(gblk), .trip_cmd_o(cmd_o),
      .all_pole_ready_o(apr), .pole_trip_o(pole), .general_trip_o(gen),
      .all_pole_trip_o(apt), .breaker_trip_o(brk));

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // One cycle: check combinational outputs, take the edge, check latches
   task automatic step();
      logic rdy, cmd, rel, relb, g1hit;
      #1;
      g1hit = (|(mc.aux_mask & `STPT_AUX_G1_SEL)) & g1;
      rdy = ready_in | mc.force_3ph | (mc.aux_mask[0] & therm) | prog
            | (g1hit & !mc.goc_1p)
            | ((|(mc.diff_mask[2:1] & diff_req[2:1])) & !(mc.gdiff_1p & !mc.force_3ph));
      cmd = (|(mc.diff_mask & diff_req)) | (mc.aux_mask[0] & therm) | g1hit | scheme | prog;
      relb = (mc.fd_sup & !fd) | gblk;
      rel = relb | mc.reduced;
      `CHK(apr, rdy)
      `CHK(cmd_o, cmd)
      `CHK(eff, mc.gdiff_1p & !mc.force_3ph)
      @(posedge clock_i);
      if (!rst_n_i)
      begin
         mc = '0;
         mp = '0;
         ma = 0;
         mb = 0;
      end
      else
      begin
         for (int p = 0; p < 3; p++)
            mp[p] = (blk[p] | rel) ? 1'b0 : ((cmd & (fault[p] | rdy)) ? 1'b1 : mp[p]);
         ma = rel ? 1'b0 : ((cmd & rdy) ? 1'b1 : ma);
         mb = (relb | !mc.reduced) ? 1'b0 : (cmd ? 1'b1 : mb);
         if (cfg_we_i)
            mc = cfg;
      end
      #1;
      `CHK(pole, mp)
      `CHK(apt, ma)
      `CHK(brk, mb)
      `CHK(gen, (|mp) | mb)
      `CHK(cfg_o, mc)
   endtask : step

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(12));
      // Settings are unknown until the first reset edge, so nothing is compared here
      repeat (6) @(posedge clock_i);
      #1;
      rst_n_i = 1;
      `CHK(cfg_o, 43'h000_0000_0000)
      `CHK({pole, apt, brk, gen}, 6'h00)
      // Force three-phase must hide a stored ground single-phase enable
      cfg_we_i = 1;
      cfg.force_3ph = 1;
      cfg.gdiff_1p = 1;
      step();
      // Reduced variant: only the breaker latch may set
      cfg.force_3ph = 0;
      cfg.reduced = 1;
      cfg.diff_mask = 3'h7;
      step();
      cfg_we_i = 0;
      diff_req = 3'h1;
      fault = 3'h2;
      repeat (2) step();
      diff_req = 3'h0;
      step();
      gblk = 1;
      step();
      gblk = 0;
      for (int i = 0; i < 800; i++)
      begin
         r = {$urandom, $urandom};
         cfg_we_i = ($urandom % 16) == 0;
         cfg = r[42:0];
         cfg.reduced = 0;
         rst_n_i = !(i == 400 || i == 401);
         diff_req = ($urandom % 4 == 0) ? 3'($urandom) : 3'h0;
         therm = ($urandom % 8) == 0;
         g1 = ($urandom % 8) == 0;
         fault = 3'(1 << ($urandom % 4));
         ready_in = ($urandom % 8) == 0;
         scheme = ($urandom % 8) == 0;
         prog = ($urandom % 16) == 0;
         fd = ($urandom % 4) != 0;
         blk = ($urandom % 4 == 0) ? 3'($urandom) : 3'h0;
         gblk = ($urandom % 16) == 0;
         step();
      end
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
